//--- verilog/eep_pkg.sv
// constants shared by the two-wire memory slave and its testbench
package eep_pkg;
    localparam logic [3:0] DEV_PREFIX = 4'ha;
    localparam int ADDR_W = 13;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int HI_W = ADDR_W - PAGE_W;
    localparam int SMALL_BYTES = 4096;
    localparam int LARGE_BYTES = 8192;
    localparam logic [ADDR_W-1:0] MASK_SMALL = 13'h0fff;
    localparam logic [ADDR_W-1:0] MASK_LARGE = 13'h1fff;
    localparam logic [ADDR_W-1:0] UQ_SMALL = 13'h0c00;
    localparam logic [ADDR_W-1:0] UQ_LARGE = 13'h1800;
    localparam int CLK_PERIOD_NS = 5;
    localparam int WR_TIME_NS = 5000000;
    localparam int WR_CYCLES_DEF = WR_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 21;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] PIN_RST = 3'h0;
    localparam logic [5:0] SYNC_RST = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
    localparam logic [PAGE_BYTES-1:0] VALID_RST = 32'h0000_0000;
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDATA, ST_RD, ST_IGNORE} eep_state_t;
endpackage

//--- verilog/eep_mem_if.sv
// port bundle between the slave logic and a storage block
`timescale 1ns/1ps
`default_nettype none
interface eep_mem_if #(parameter int AW = 5, parameter int DW = 8);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- verilog/eep_mem.sv
// simple dual-port storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module eep_mem #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input wire logic i_clk,
    eep_mem_if.mem port
);
    logic [DW-1:0] store [2**AW];
    logic [DW-1:0] rdata_ff;

    always_ff @(posedge i_clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
        rdata_ff <= store[port.raddr];
    end

    assign port.rdata = rdata_ff;
endmodule
`default_nettype wire

//--- verilog/eep_slave.sv
// two-wire serial memory slave: framing, addressing, page write, read and programming cycle
// Function
// - falling data while clock high starts
// - rising data while clock high stops
// - data changes only while clock low
// - respond only on prefix and select pins
// - last address bit picks read or write
// - transmitter releases, receiver acks ninth clock
// - ack matching address and each write byte
// - read continues next byte on ack
// - no ack ends output, await stop
// - stop after read returns to standby
// - array holds 4096 or 8192 bytes
// - lock pin blocks upper-quarter writes
// - floating lock pin means writes allowed; there is no pull-down here, so the lock pin must be driven low
// - byte write is address, word address, data
// - stop after write starts programming cycle
// - programming cycle ignores every bus request
// - only five low address bits increment
// - over 32 bytes wraps and overwrites page
// - no ack while busy, ack when done
// - address counter is last access plus one
`timescale 1ns/1ps
`default_nettype none
module eep_slave #(
    parameter int WR_CYCLES = eep_pkg::WR_CYCLES_DEF,
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_dev_sel0,
    input wire logic i_dev_sel1,
    input wire logic i_dev_sel2,
    input wire logic i_upper_quarter_write_lock,
    output logic o_prog_busy,
    output logic o_standby
);
    import eep_pkg::*;

    logic [5:0] pins;
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic [5:0] sync3_ff;
    logic [5:0] filt_ff;
    logic [5:0] prev_ff;
    logic [5:0] nxt_filt;

    eep_state_t state_ff;
    eep_state_t nxt_state;
    logic [3:0] bit_cnt_ff;
    logic [3:0] nxt_bit_cnt;
    logic ack_ff;
    logic nxt_ack;
    logic [7:0] shreg_ff;
    logic [7:0] nxt_shreg;
    logic oe_ff;
    logic nxt_oe;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic mack_ff;
    logic nxt_mack;
    logic pend_ff;
    logic nxt_pend;
    logic [PAGE_BYTES-1:0] valid_ff;
    logic [PAGE_BYTES-1:0] nxt_valid;
    logic [HI_W-1:0] page_hi_ff;
    logic [HI_W-1:0] nxt_page_hi;
    logic busy_ff;
    logic nxt_busy;
    logic [CNT_W-1:0] wcnt_ff;
    logic [CNT_W-1:0] nxt_wcnt;
    logic standby_ff;
    logic sda_out_ff;
    logic buf_we;

    eep_mem_if #(.AW(PAGE_W), .DW(8)) page_if ();
    eep_mem_if #(.AW(ADDR_W), .DW(8)) array_if ();

    eep_mem #(.AW(PAGE_W), .DW(8)) u_page (
        .i_clk(i_clk_sys),
        .port(page_if.mem)
    );

    eep_mem #(.AW(ADDR_W), .DW(8)) u_array (
        .i_clk(i_clk_sys),
        .port(array_if.mem)
    );

    // pin order: lock, sel2, sel1, sel0, data, clock
    // no pull-down on lock: only reset loads its synchroniser stages low
    assign pins = {i_upper_quarter_write_lock, i_dev_sel2, i_dev_sel1, i_dev_sel0, i_sda_in, i_scl};

    // a pin change is taken once the second and third stages agree
    assign nxt_filt = (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (filt_ff & (sync2_ff ^ sync3_ff));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
            sync3_ff <= SYNC_RST;
            filt_ff <= SYNC_RST;
            prev_ff <= SYNC_RST;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
        end
    end

    wire scl = filt_ff[0];
    wire sda = filt_ff[1];
    wire [2:0] dev_sel = filt_ff[4:2];
    wire wlock = filt_ff[5];
    wire scl_rise = scl & ~prev_ff[0];
    wire scl_fall = ~scl & prev_ff[0];
    wire start_det = scl & prev_ff[0] & prev_ff[1] & ~sda;
    wire stop_det = scl & prev_ff[0] & ~prev_ff[1] & sda;

    wire [ADDR_W-1:0] addr_mask = LARGE_VARIANT ? MASK_LARGE : MASK_SMALL;
    wire [ADDR_W-1:0] uq_base = LARGE_VARIANT ? UQ_LARGE : UQ_SMALL;
    wire wr_blocked = wlock & (addr_ff >= uq_base);
    wire dev_match = (shreg_ff[7:4] == DEV_PREFIX) & (shreg_ff[3:1] == dev_sel);
    wire byte_done = scl_fall & ~ack_ff & (bit_cnt_ff == BITS_PER_BYTE);
    wire active = (state_ff != ST_IDLE) & (state_ff != ST_IGNORE);
    wire [ADDR_W-1:0] addr_inc = (addr_ff + 13'h0001) & addr_mask;
    wire [ADDR_W-1:0] addr_page_inc = {addr_ff[ADDR_W-1:PAGE_W], addr_ff[PAGE_W-1:0] + 5'h01};
    wire [4:0] cmt_idx = wcnt_ff[4:0] - 5'h01;
    wire cmt_slot = (wcnt_ff >= 21'h000001) & (wcnt_ff <= 21'h000020);
    wire wr_last = (wcnt_ff == CNT_W'(WR_CYCLES - 1));

    assign page_if.we = buf_we;
    assign page_if.waddr = addr_ff[PAGE_W-1:0];
    assign page_if.wdata = shreg_ff;
    assign page_if.raddr = wcnt_ff[PAGE_W-1:0];
    assign array_if.we = busy_ff & cmt_slot & valid_ff[cmt_idx];
    assign array_if.waddr = {page_hi_ff, cmt_idx};
    assign array_if.wdata = page_if.rdata;
    assign array_if.raddr = addr_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_ack = ack_ff;
        nxt_shreg = shreg_ff;
        nxt_oe = oe_ff;
        nxt_addr = addr_ff;
        nxt_mack = mack_ff;
        nxt_pend = pend_ff;
        nxt_valid = valid_ff;
        nxt_page_hi = page_hi_ff;
        nxt_busy = busy_ff;
        nxt_wcnt = wcnt_ff;
        buf_we = 1'b0;
        if (busy_ff) begin
            nxt_wcnt = wcnt_ff + 21'h000001;
            nxt_state = ST_IDLE;
            nxt_oe = 1'b0;
            if (wr_last) begin
                nxt_busy = 1'b0;
                nxt_wcnt = '0;
            end
        end else if (stop_det) begin
            nxt_state = ST_IDLE;
            nxt_ack = 1'b0;
            nxt_oe = 1'b0;
            if (pend_ff) begin
                nxt_busy = 1'b1;
                nxt_wcnt = '0;
                nxt_pend = 1'b0;
            end
        end else if (start_det) begin
            nxt_state = ST_DEV;
            nxt_bit_cnt = '0;
            nxt_ack = 1'b0;
            nxt_oe = 1'b0;
        end else if (active) begin
            if (scl_rise) begin
                if (ack_ff) begin
                    nxt_mack = ~sda;
                end else begin
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    if (state_ff != ST_RD) begin
                        nxt_shreg = {shreg_ff[6:0], sda};
                    end
                end
            end else if (scl_fall && ack_ff) begin
                nxt_ack = 1'b0;
                nxt_bit_cnt = '0;
                nxt_oe = 1'b0;
                if (state_ff == ST_RD) begin
                    if (mack_ff) begin
                        nxt_shreg = array_if.rdata;
                        nxt_oe = ~array_if.rdata[7];
                        nxt_addr = addr_inc;
                    end else begin
                        nxt_state = ST_IGNORE;
                    end
                end
            end else if (byte_done) begin
                nxt_ack = 1'b1;
                nxt_oe = 1'b1;
                case (state_ff)
                    ST_DEV: begin
                        if (!dev_match) begin
                            nxt_state = ST_IGNORE;
                            nxt_ack = 1'b0;
                            nxt_oe = 1'b0;
                        end else if (shreg_ff[0]) begin
                            nxt_state = ST_RD;
                            nxt_mack = 1'b1;
                        end else begin
                            nxt_state = ST_AHI;
                            nxt_valid = VALID_RST;
                        end
                    end
                    ST_AHI: begin
                        nxt_addr = {shreg_ff[4:0], addr_ff[7:0]} & addr_mask;
                        nxt_state = ST_ALO;
                    end
                    ST_ALO: begin
                        nxt_addr = {addr_ff[ADDR_W-1:8], shreg_ff};
                        nxt_state = ST_WDATA;
                    end
                    ST_WDATA: begin
                        buf_we = 1'b1;
                        nxt_valid[addr_ff[PAGE_W-1:0]] = ~wr_blocked;
                        nxt_pend = 1'b1;
                        nxt_page_hi = addr_ff[ADDR_W-1:PAGE_W];
                        nxt_addr = addr_page_inc;
                    end
                    ST_RD: begin
                        nxt_oe = 1'b0;
                        nxt_mack = 1'b0;
                    end
                    default: begin
                        nxt_state = ST_IGNORE;
                        nxt_ack = 1'b0;
                        nxt_oe = 1'b0;
                    end
                endcase
            end else if (scl_fall && (state_ff == ST_RD) && (bit_cnt_ff != 4'h0)) begin
                nxt_shreg = {shreg_ff[6:0], 1'b0};
                nxt_oe = ~shreg_ff[6];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= '0;
            ack_ff <= 1'b0;
            shreg_ff <= '0;
            oe_ff <= 1'b0;
            mack_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            ack_ff <= nxt_ack;
            shreg_ff <= nxt_shreg;
            oe_ff <= nxt_oe;
            mack_ff <= nxt_mack;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            addr_ff <= ADDR_RST;
            pend_ff <= 1'b0;
            valid_ff <= VALID_RST;
            page_hi_ff <= '0;
            busy_ff <= 1'b0;
            wcnt_ff <= '0;
            standby_ff <= 1'b1;
            sda_out_ff <= 1'b0;
        end else begin
            addr_ff <= nxt_addr;
            pend_ff <= nxt_pend;
            valid_ff <= nxt_valid;
            page_hi_ff <= nxt_page_hi;
            busy_ff <= nxt_busy;
            wcnt_ff <= nxt_wcnt;
            standby_ff <= (nxt_state == ST_IDLE) & ~nxt_busy;
            sda_out_ff <= 1'b0;
        end
    end

    assign o_sda_out = sda_out_ff;
    assign o_sda_oe = oe_ff;
    assign o_prog_busy = busy_ff;
    assign o_standby = standby_ff;
endmodule
`default_nettype wire

//--- verification/eep_checker.sv
// port assertions for the two-wire memory slave
`timescale 1ns/1ps
`default_nettype none
module eep_checker #(
    parameter int WR_CYCLES = 200
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda_in,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_prog_busy,
    input wire logic o_standby
);
    logic [31:0] busy_len_ff;
    logic [31:0] nxt_busy_len;
    assign nxt_busy_len = o_prog_busy ? busy_len_ff + 32'h1 : 32'h0;
    always_ff @(posedge i_clk_sys) begin
        busy_len_ff <= i_rst ? 32'h0 : nxt_busy_len;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_bus_idle;
        i_scl && i_sda_in;
    endsequence
    sequence s_busy_hold;
        o_prog_busy [*8];
    endsequence
    a_busy_no_drive: assert property (o_prog_busy |-> !o_sda_oe) else $error("drive while busy");
    a_busy_full_len: assert property ($fell(o_prog_busy) |-> busy_len_ff == WR_CYCLES)
        else $error("busy length wrong");
    a_busy_after_stop: assert property ($rose(o_prog_busy) |-> s_bus_idle) else $error("busy without stop");
    a_busy_min_hold: assert property ($rose(o_prog_busy) |-> s_busy_hold) else $error("busy too short");
    a_busy_not_idle: assert property (o_prog_busy |-> !o_standby) else $error("standby while busy");
    a_standby_quiet: assert property (o_standby |-> !o_sda_oe) else $error("drive in standby");
    a_open_drain: assert property (!o_sda_out) else $error("data driven high");
    a_ack_stands: assert property ($rose(o_sda_oe) |-> o_sda_oe [*3]) else $error("ack too short");
endmodule
bind eep_slave eep_checker #(.WR_CYCLES(WR_CYCLES)) i_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(i_scl),
    .i_sda_in(i_sda_in), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_prog_busy(o_prog_busy),
    .o_standby(o_standby));
`default_nettype wire

//--- verification/eep_master_model.sv
// two-wire bus master model that drives clock and pulls data low
`timescale 1ns/1ps
`default_nettype none
module eep_master_model (
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial begin
        o_scl = 1'h1;
        o_sda_low = 1'h0;
    end
    // data moves while clock low
    // a 30 ns low phase outlasts the slave's synchroniser delay before it drives
    task automatic clk_bit(input logic b, output logic s);
        #12 o_sda_low = !b;
        #18 o_scl = 1'h1;
        #14 s = i_sda;
        #4 o_scl = 1'h0;
    endtask
    task automatic start();
        @(negedge i_clk_sys);
        #1 o_sda_low = 1'h0;
        #30 o_scl = 1'h1;
        #24 o_sda_low = 1'h1;
        #24 o_scl = 1'h0;
    endtask
    task automatic stop();
        #12 o_sda_low = 1'h1;
        #18 o_scl = 1'h1;
        #24 o_sda_low = 1'h0;
        #24;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'h1, ack);
    endtask
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'h1, s);
            d[i] = s;
        end
        clk_bit(!mack, s);
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// bench for the two-wire memory slave: address match, writes, page wrap, lock, polling
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import eep_pkg::*;
    localparam int WR_N = 200;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic lock = 1'h0;
    logic [2:0] sel = 3'h5;
    wire scl;
    wire mst_low;
    wire sda_oe;
    wire sda_out;
    wire busy;
    wire stby;
    wire sda = !(mst_low || (sda_oe && !sda_out));
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int poll_n;
    logic ack;
    logic [7:0] d;
    logic [7:0] got[$];
    eep_slave #(.WR_CYCLES(WR_N), .LARGE_VARIANT(1'h1)) i_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_scl(scl),
        .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_dev_sel0(sel[0]), .i_dev_sel1(sel[1]),
        .i_dev_sel2(sel[2]), .i_upper_quarter_write_lock(lock), .o_prog_busy(busy), .o_standby(stby));
    eep_master_model i_mst (.i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(mst_low));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] dev(input logic rw);
        return {DEV_PREFIX, sel, rw};
    endfunction
    task automatic send_addr(input logic [15:0] a);
        i_mst.start();
        i_mst.wr_byte(dev(1'h0), ack);
        chk("dev ack", 8'(ack), 8'h00);
        i_mst.wr_byte(a[15:8], ack);
        chk("addr hi ack", 8'(ack), 8'h00);
        i_mst.wr_byte(a[7:0], ack);
        chk("addr lo ack", 8'(ack), 8'h00);
    endtask
    task automatic do_write(input logic [15:0] a, input int n, input logic [7:0] base);
        send_addr(a);
        for (int i = 0; i < n; i++) begin
            i_mst.wr_byte(base + 8'(i), ack);
            chk("data ack", 8'(ack), 8'h00);
        end
        i_mst.stop();
    endtask
    task automatic wait_idle();
        poll_n = 0;
        ack = 1'h1;
        while (ack !== 1'h0 && poll_n < 100) begin
            i_mst.start();
            i_mst.wr_byte(dev(1'h0), ack);
            poll_n++;
        end
        i_mst.stop();
    endtask
    task automatic rd_at(input logic [15:0] a, input int n, input logic cur);
        got.delete();
        if (!cur) send_addr(a);
        i_mst.start();
        i_mst.wr_byte(dev(1'h1), ack);
        chk("read dev ack", 8'(ack), 8'h00);
        for (int i = 0; i < n; i++) begin
            i_mst.rd_byte(i < n - 1, d);
            got.push_back(d);
        end
        i_mst.stop();
    endtask
    task automatic t_sel();
        logic [7:0] bad[4];
        bad = '{{4'h9, sel, 1'h0}, {DEV_PREFIX, sel ^ 3'h1, 1'h0}, {DEV_PREFIX, sel ^ 3'h2, 1'h1},
            {DEV_PREFIX, sel ^ 3'h4, 1'h0}};
        foreach (bad[i]) begin
            i_mst.start();
            i_mst.wr_byte(bad[i], ack);
            chk("foreign address", 8'(ack), 8'h01);
            i_mst.stop();
        end
        $display("test address match done");
    endtask
    task automatic t_byte();
        do_write(16'h0123, 2, 8'ha5);
        repeat (8) @(negedge clk_sys);
        chk("busy after stop", 8'(busy), 8'h01);
        chk("no standby busy", 8'(stby), 8'h00);
        wait_idle();
        chk("polls refused", 8'(poll_n > 1 && poll_n < 100), 8'h01);
        rd_at(16'h0123, 2, 1'h0);
        chk("read back", got[0], 8'ha5);
        chk("read next", got[1], 8'ha6);
        repeat (8) @(negedge clk_sys);
        chk("standby after read", 8'(stby), 8'h01);
        $display("test byte write done");
    endtask
    task automatic t_page();
        do_write(16'h005e, 34, 8'h01);
        wait_idle();
        rd_at(16'h0040, 32, 1'h0);
        for (int k = 0; k < 32; k++) chk("page byte", got[k], 8'(k + 3));
        rd_at(16'h005d, 1, 1'h0);
        rd_at(16'h0000, 1, 1'h1);
        chk("current address", got[0], 8'h21);
        $display("test page wrap done");
    endtask
    task automatic t_lock();
        do_write(16'h1800, 1, 8'h11);
        wait_idle();
        @(negedge clk_sys) lock = 1'h1;
        do_write(16'h1800, 1, 8'h22);
        wait_idle();
        do_write(16'h17ff, 1, 8'h44);
        wait_idle();
        rd_at(16'h17ff, 2, 1'h0);
        chk("below quarter", got[0], 8'h44);
        chk("locked quarter", got[1], 8'h11);
        @(negedge clk_sys) lock = 1'h0;
        $display("test write lock done");
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'h0;
        repeat (6) @(negedge clk_sys);
        chk("standby after reset", 8'(stby), 8'h01);
        t_sel();
        t_byte();
        t_page();
        t_lock();
        close_out();
    end
endmodule
`default_nettype wire
